// ===== logic/sks_pkg.sv
package sks_pkg;
   // generic sampler state dword 0 fields
   localparam int KEY_EN_BIT = 25;
   localparam int KEY_IDX_HI = 24;
   localparam int KEY_IDX_LO = 23;
   localparam int KEY_MODE_BIT = 22;
   localparam int ANISO_HI = 21;
   localparam int ANISO_LO = 19;
   localparam int ROUND_HI = 18;
   localparam int ROUND_LO = 13;
   localparam logic KEY_KILL_ON_MATCH = 1'h0;
   localparam logic KEY_REPLACE_WITH_BLACK = 1'h1;
   localparam logic [2:0] ANISO_RATIO_CODE_MIN = 3'h0;
   localparam logic [2:0] ANISO_RATIO_CODE_MAX = 3'h7;
   // eight-by-eight state dword 0
   localparam int E8_SCALER_TYPE_BIT = 31;
   localparam int E8_BYPASS_BIT = 29;
   localparam int E8_IEF_TYPE_BIT = 28;
   localparam int E8_IEF_SIZE_BIT = 27;
   localparam int E8_KEY_EN_BIT = 18;
   localparam int E8_KEY_IDX_HI = 17;
   localparam int E8_KEY_IDX_LO = 16;
   // dword 1 .. 4
   localparam int STRONG_TH_HI = 7;
   localparam int STRONG_TH_LO = 4;
   localparam int WEAK_TH_HI = 3;
   localparam int WEAK_TH_LO = 0;
   localparam int STRONG_W_LO = 28;
   localparam int REGULAR_W_LO = 24;
   localparam int NON_W_LO = 20;
   localparam int STEEP_TH_HI = 11;
   localparam int STEEP_TH_LO = 8;
   localparam int STEEP_BOOST_BIT = 7;
   localparam int MR_TH_HI = 6;
   localparam int MR_TH_LO = 3;
   localparam int MR_BOOST_BIT = 2;
   localparam int PTR_HI = 31;
   localparam int PTR_LO = 5;
   // state array layout
   localparam int E8_INDEX_STRIDE = 4;
   localparam int E8_ELEMENT_DWORDS = 16;
   localparam int E8_ALIGN_BYTES = 32;
   // black texel values
   localparam logic [7:0] BLACK_LUMA = 8'h10;
   localparam logic [7:0] BLACK_CHROMA = 8'h80;
   // host register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DW0 = 8'h04;
   localparam logic [7:0] OFS_DW1 = 8'h08;
   localparam logic [7:0] OFS_DW2 = 8'h0C;
   localparam logic [7:0] OFS_DW3 = 8'h10;
   localparam logic [7:0] OFS_DW4 = 8'h14;
   localparam logic [7:0] OFS_TEX0 = 8'h18;
   localparam logic [7:0] OFS_MEAS = 8'h28;
   localparam logic [7:0] OFS_KEY0 = 8'h2C;
   localparam logic [7:0] OFS_STATUS = 8'h3C;
   localparam logic [7:0] OFS_RES0 = 8'h40;
   localparam logic [7:0] OFS_RTEX0 = 8'h44;
   localparam logic [7:0] OFS_RES1 = 8'h54;
   localparam int CTRL_START = 0;
   localparam int CTRL_FLUSH = 1;
   localparam int CTRL_IS8X8 = 2;
   localparam int CTRL_MRET = 3;
   localparam int CTRL_FMT10 = 4;
   localparam int CTRL_YUV = 5;
   localparam int CTRL_LIVE = 6;
   localparam int CTRL_IDX_LO = 8;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_PTR_ERR = 2;
   localparam int ST_IDX_ERR = 3;
   // reset values of staged state dwords 2 to 4 (documented field defaults)
   localparam logic [31:0] DW2_RESET = 32'h0000_1681;
   localparam logic [31:0] DW3_RESET = 32'h721A_03C6;
   localparam logic [31:0] DW4_RESET = 32'h0C82_4028;
   typedef enum logic [2:0] {
      SKS_IDLE = 3'b001,
      SKS_SEND = 3'b010,
      SKS_WAIT = 3'b100
   } sks_state_t;
endpackage : sks_pkg

// ===== logic/sks_link_if.sv
`timescale 1ns/10ps
interface sks_link_if;
   // request, thread side to sampler
   logic req_valid;
   logic req_ready;
   logic req_is_8x8;
   logic req_mask_return;
   logic req_fmt_10bit;
   logic req_fmt_yuv;
   logic req_pixel_live;
   logic [3:0] req_sampler_index;
   logic [31:0] req_dw0;
   logic [31:0] req_dw2;
   logic [31:0] req_dw3;
   logic [31:0] req_dw4;
   logic [3:0][31:0] req_texel;
   logic [3:0][31:0] req_key_table;
   logic [7:0] req_edge_mag;
   logic [7:0] req_steep;
   logic [7:0] req_mr;
   logic [7:0] req_slope;
   // response
   logic resp_valid;
   logic resp_ready;
   logic [31:0] resp_info;
   logic [31:0] resp_meas;
   logic [3:0][31:0] resp_texel;
   logic resp_idx_err;
   modport device (input req_valid, req_is_8x8, req_mask_return, req_fmt_10bit, req_fmt_yuv, req_pixel_live,
      req_sampler_index, req_dw0, req_dw2, req_dw3, req_dw4, req_texel, req_key_table, req_edge_mag,
      req_steep, req_mr, req_slope, resp_ready,
      output req_ready, resp_valid, resp_info, resp_meas, resp_texel, resp_idx_err);
   modport thread (output req_valid, req_is_8x8, req_mask_return, req_fmt_10bit, req_fmt_yuv, req_pixel_live,
      req_sampler_index, req_dw0, req_dw2, req_dw3, req_dw4, req_texel, req_key_table, req_edge_mag,
      req_steep, req_mr, req_slope, resp_ready,
      input req_ready, resp_valid, resp_info, resp_meas, resp_texel, resp_idx_err);
endinterface : sks_link_if

// ===== logic/sks_sampler.sv
`timescale 1ns/10ps
module sks_sampler (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // message link
   sks_link_if.device link,
   // user side
   output logic key_hit_seen_r,
   output logic [15:0] served_count_r
);
   logic accept;
   logic key_en;
   logic [1:0] key_idx;
   logic replace_mode;
   logic [31:0] key;
   logic [3:0] match;
   logic [3:0][31:0] texel_nxt;
   logic [31:0] black;
   logic [4:0] aniso_max;
   logic [5:0] round_en;
   logic bypass;
   logic nearest;
   logic [1:0] edge_class;
   logic [2:0] weight;
   logic [3:0] strong_th;
   logic [3:0] weak_th;
   logic [8:0] steep_gain;
   logic [8:0] mr_gain;
   logic signed [11:0] sharpen;
   logic mask_out;
   logic [31:0] info_nxt;
   logic [31:0] meas_nxt;

   assign accept = link.req_valid && link.req_ready;

   // only named fields are read; every other state bit is dropped here
   always_comb begin
      if (link.req_is_8x8) begin
         key_en = link.req_dw0[sks_pkg::E8_KEY_EN_BIT];
         key_idx = link.req_dw0[sks_pkg::E8_KEY_IDX_HI:sks_pkg::E8_KEY_IDX_LO];
         replace_mode = sks_pkg::KEY_REPLACE_WITH_BLACK;
         aniso_max = 5'h00;
         round_en = 6'h00;
         nearest = link.req_dw0[sks_pkg::E8_SCALER_TYPE_BIT];
         bypass = link.req_dw0[sks_pkg::E8_BYPASS_BIT];
      end else begin
         key_en = link.req_dw0[sks_pkg::KEY_EN_BIT];
         key_idx = link.req_dw0[sks_pkg::KEY_IDX_HI:sks_pkg::KEY_IDX_LO];
         replace_mode = link.req_dw0[sks_pkg::KEY_MODE_BIT];
         // ratio is 2*(code+1)
         aniso_max = {1'b0, link.req_dw0[sks_pkg::ANISO_HI:sks_pkg::ANISO_LO], 1'b0} + 5'h02;
         // bit 5 U mag, 4 U min, 3 V mag, 2 V min, 1 R mag, 0 R min
         round_en = link.req_dw0[sks_pkg::ROUND_HI:sks_pkg::ROUND_LO];
         nearest = 1'b0;
         bypass = 1'b0;
      end
   end

   // the index is only looked at with keying on; otherwise entry 0 is read but unused
   assign key = key_en ? link.req_key_table[key_idx] : link.req_key_table[0];

   always_comb begin
      if (link.req_fmt_yuv) begin
         black = {8'h00, sks_pkg::BLACK_CHROMA, sks_pkg::BLACK_LUMA, sks_pkg::BLACK_CHROMA};
         if (link.req_fmt_10bit) begin
            black = {2'h0, sks_pkg::BLACK_CHROMA, 2'h0, sks_pkg::BLACK_LUMA, 2'h0, sks_pkg::BLACK_CHROMA, 2'h0};
         end
      end else begin
         black = 32'h0000_0000;
      end
   end

   // colour channels are compared, alpha is not
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (link.req_fmt_10bit) begin
            match[i] = key_en && link.req_texel[i][29:22] == key[23:16] && link.req_texel[i][19:12] == key[15:8]
               && link.req_texel[i][9:2] == key[7:0];
         end else begin
            match[i] = key_en && link.req_texel[i][23:0] == key[23:0];
         end
         texel_nxt[i] = (match[i] && replace_mode) ? black : link.req_texel[i];
      end
   end

   // a disabled key gives no match, so the mode bit has no effect
   assign mask_out = link.req_pixel_live && !(replace_mode == sks_pkg::KEY_KILL_ON_MATCH && |match);

   always_comb begin
      strong_th = link.req_dw2[sks_pkg::STRONG_TH_HI:sks_pkg::STRONG_TH_LO];
      weak_th = link.req_dw2[sks_pkg::WEAK_TH_HI:sks_pkg::WEAK_TH_LO];
      edge_class = 2'h0;
      weight = link.req_dw3[sks_pkg::NON_W_LO +: 3];
      if (link.req_edge_mag > {4'h0, strong_th}) begin
         edge_class = 2'h2;
         weight = link.req_dw3[sks_pkg::STRONG_W_LO +: 3];
      end else if (link.req_edge_mag > {4'h0, weak_th} && link.req_edge_mag < {4'h0, strong_th}) begin
         edge_class = 2'h1;
         weight = link.req_dw3[sks_pkg::REGULAR_W_LO +: 3];
      end
      steep_gain = 9'h000;
      if (link.req_steep > {4'h0, link.req_dw4[sks_pkg::STEEP_TH_HI:sks_pkg::STEEP_TH_LO]}) begin
         steep_gain = link.req_dw4[sks_pkg::STEEP_BOOST_BIT] ? {link.req_steep, 1'b0}
            : {1'b0, link.req_steep};
      end
      mr_gain = 9'h000;
      if (link.req_mr > {4'h0, link.req_dw4[sks_pkg::MR_TH_HI:sks_pkg::MR_TH_LO]}) begin
         mr_gain = link.req_dw4[sks_pkg::MR_BOOST_BIT] ? {link.req_mr, 1'b0} : {1'b0, link.req_mr};
      end
      // neutral analyzer output when enhancement is skipped
      if (bypass) begin
         edge_class = 2'h0;
         weight = 3'h0;
         steep_gain = 9'h000;
         mr_gain = 9'h000;
      end
   end

   // S3.4 slope times the unsigned weight keeps four fraction bits
   assign sharpen = 12'($signed(link.req_slope) * $signed({1'b0, weight}));

   always_comb begin
      info_nxt = 32'h0000_0000;
      info_nxt[0] = link.req_mask_return;
      info_nxt[1] = link.req_mask_return ? mask_out : 1'b0;
      info_nxt[2] = |match;
      info_nxt[3] = nearest;
      info_nxt[4] = bypass;
      info_nxt[6:5] = edge_class;
      info_nxt[9:7] = weight;
      info_nxt[14:10] = aniso_max;
      info_nxt[20:15] = round_en;
      info_nxt[22:21] = link.req_sampler_index[3:2];
      meas_nxt = {2'h0, sharpen, mr_gain, steep_gain};
   end

   // one-entry output stage; a new message is taken when it is empty or draining
   assign link.req_ready = !link.resp_valid || link.resp_ready;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link.resp_valid <= 1'b0;
      end else if (accept) begin
         link.resp_valid <= 1'b1;
      end else if (link.resp_ready) begin
         link.resp_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link.resp_info <= 32'h0000_0000;
         link.resp_meas <= 32'h0000_0000;
         link.resp_texel <= '0;
         link.resp_idx_err <= 1'b0;
      end else if (accept) begin
         link.resp_info <= info_nxt;
         link.resp_meas <= meas_nxt;
         link.resp_texel <= texel_nxt;
         // an 8x8 index must be a multiple of the element stride
         link.resp_idx_err <= link.req_is_8x8 && link.req_sampler_index[1:0] != 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         key_hit_seen_r <= 1'b0;
         served_count_r <= 16'h0000;
      end else if (accept) begin
         key_hit_seen_r <= key_hit_seen_r || |match;
         served_count_r <= served_count_r + 16'h0001;
      end
   end
endmodule : sks_sampler

// ===== logic/sks_thread.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
module sks_thread (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // message link
   sks_link_if.thread link
);
   logic [31:0] ctrl_r;
   logic [4:0][31:0] dw_r;
   logic [3:0][31:0] tex_r;
   logic [31:0] meas_r;
   logic [3:0][31:0] key_r;
   logic [3:0] status_r;
   logic [31:0] res0_r;
   logic [31:0] res1_r;
   logic [3:0][31:0] rtex_r;
   logic [26:0] last_ptr_r;
   logic ptr_valid_r;
   sks_pkg::sks_state_t state_r;
   logic access;
   logic wr;
   logic mapped;
   logic [31:0] rdata;
   logic start;
   logic ptr_clash;
   logic [31:0] dw0_out;
   logic [31:0] ctrl_now;

   assign access = psel && penable;
   assign wr = access && pready && pwrite;
   assign start = wr && paddr == sks_pkg::OFS_CTRL && pwdata[sks_pkg::CTRL_START];
   // the start write carries the message fields; ctrl_r still holds the previous ones
   assign ctrl_now = start ? pwdata : ctrl_r;
   assign ptr_clash = ctrl_now[sks_pkg::CTRL_IS8X8] && ptr_valid_r
      && last_ptr_r != dw_r[1][sks_pkg::PTR_HI:sks_pkg::PTR_LO];

   always_comb begin
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      case (paddr)
         sks_pkg::OFS_CTRL: rdata = ctrl_r;
         sks_pkg::OFS_DW0, sks_pkg::OFS_DW1, sks_pkg::OFS_DW2, sks_pkg::OFS_DW3, sks_pkg::OFS_DW4:
            rdata = dw_r[3'((paddr - sks_pkg::OFS_DW0) >> 2)];
         sks_pkg::OFS_MEAS: rdata = meas_r;
         sks_pkg::OFS_STATUS: rdata = {28'h0000000, status_r};
         sks_pkg::OFS_RES0: rdata = res0_r;
         sks_pkg::OFS_RES1: rdata = res1_r;
         default: begin
            if (paddr >= sks_pkg::OFS_TEX0 && paddr < sks_pkg::OFS_MEAS && paddr[1:0] == 2'h0) begin
               rdata = tex_r[2'((paddr - sks_pkg::OFS_TEX0) >> 2)];
            end else if (paddr >= sks_pkg::OFS_KEY0 && paddr < sks_pkg::OFS_STATUS && paddr[1:0] == 2'h0) begin
               rdata = key_r[2'((paddr - sks_pkg::OFS_KEY0) >> 2)];
            end else if (paddr >= sks_pkg::OFS_RTEX0 && paddr < sks_pkg::OFS_RES1 && paddr[1:0] == 2'h0) begin
               rdata = rtex_r[2'((paddr - sks_pkg::OFS_RTEX0) >> 2)];
            end else begin
               mapped = 1'b0;
            end
         end
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rdata;
         pslverr <= !mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // staged message words; start bit self-clears
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_r <= 32'h0000_0000;
         dw_r <= {sks_pkg::DW4_RESET, sks_pkg::DW3_RESET, sks_pkg::DW2_RESET, 32'h0000_0000, 32'h0000_0000};
         tex_r <= '0;
         meas_r <= 32'h0000_0000;
         key_r <= '0;
      end else if (wr && mapped) begin
         case (paddr)
            sks_pkg::OFS_CTRL: ctrl_r <= {pwdata[31:2], 2'h0};
            sks_pkg::OFS_DW0, sks_pkg::OFS_DW1, sks_pkg::OFS_DW2, sks_pkg::OFS_DW3, sks_pkg::OFS_DW4:
               dw_r[3'((paddr - sks_pkg::OFS_DW0) >> 2)] <= pwdata;
            sks_pkg::OFS_MEAS: meas_r <= pwdata;
            default: begin
               if (paddr >= sks_pkg::OFS_TEX0 && paddr < sks_pkg::OFS_MEAS) begin
                  tex_r[2'((paddr - sks_pkg::OFS_TEX0) >> 2)] <= pwdata;
               end else if (paddr >= sks_pkg::OFS_KEY0 && paddr < sks_pkg::OFS_STATUS) begin
                  key_r[2'((paddr - sks_pkg::OFS_KEY0) >> 2)] <= pwdata;
               end
            end
         endcase
      end
   end

   // detail filter demands the 5x5 size, so the size bit is forced on
   always_comb begin
      dw0_out = dw_r[0];
      if (dw_r[0][sks_pkg::E8_IEF_TYPE_BIT]) begin
         dw0_out[sks_pkg::E8_IEF_SIZE_BIT] = 1'b1;
      end
   end

   // flush forgets the pointer so a new primitive may bring another one
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ptr_valid_r <= 1'b0;
         last_ptr_r <= 27'h0000000;
      end else if (wr && paddr == sks_pkg::OFS_CTRL && pwdata[sks_pkg::CTRL_FLUSH]) begin
         ptr_valid_r <= 1'b0;
      end else if (state_r == sks_pkg::SKS_SEND && link.req_ready && link.req_is_8x8) begin
         ptr_valid_r <= 1'b1;
         last_ptr_r <= dw_r[1][sks_pkg::PTR_HI:sks_pkg::PTR_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= sks_pkg::SKS_IDLE;
      end else begin
         case (state_r)
            sks_pkg::SKS_IDLE: if (start && !ptr_clash) state_r <= sks_pkg::SKS_SEND;
            sks_pkg::SKS_SEND: if (link.req_ready) state_r <= sks_pkg::SKS_WAIT;
            sks_pkg::SKS_WAIT: if (link.resp_valid) state_r <= sks_pkg::SKS_IDLE;
            default: state_r <= sks_pkg::SKS_IDLE;
         endcase
      end
   end

   // status: done and errors are sticky, cleared by writing one; a new set wins
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         status_r <= 4'h0;
         res0_r <= 32'h0000_0000;
         res1_r <= 32'h0000_0000;
         rtex_r <= '0;
      end else begin
         status_r[sks_pkg::ST_BUSY] <= state_r != sks_pkg::SKS_IDLE || (start && !ptr_clash);
         for (int b = sks_pkg::ST_DONE; b <= sks_pkg::ST_IDX_ERR; b++) begin
            if (wr && paddr == sks_pkg::OFS_STATUS && pwdata[b]) begin
               status_r[b] <= 1'b0;
            end
         end
         if (start && ptr_clash && state_r == sks_pkg::SKS_IDLE) begin
            status_r[sks_pkg::ST_PTR_ERR] <= 1'b1;
         end
         if (state_r == sks_pkg::SKS_WAIT && link.resp_valid) begin
            status_r[sks_pkg::ST_DONE] <= 1'b1;
            if (link.resp_idx_err) begin
               status_r[sks_pkg::ST_IDX_ERR] <= 1'b1;
            end
            res0_r <= link.resp_info;
            res1_r <= link.resp_meas;
            rtex_r <= link.resp_texel;
         end
      end
   end

   // request fields held while in SEND
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         link.req_valid <= 1'b0;
         link.req_is_8x8 <= 1'b0;
         link.req_mask_return <= 1'b0;
         link.req_fmt_10bit <= 1'b0;
         link.req_fmt_yuv <= 1'b0;
         link.req_pixel_live <= 1'b0;
         link.req_sampler_index <= 4'h0;
         link.req_dw0 <= 32'h0000_0000;
         link.req_dw2 <= 32'h0000_0000;
         link.req_dw3 <= 32'h0000_0000;
         link.req_dw4 <= 32'h0000_0000;
         link.req_texel <= '0;
         link.req_key_table <= '0;
         link.req_edge_mag <= 8'h00;
         link.req_steep <= 8'h00;
         link.req_mr <= 8'h00;
         link.req_slope <= 8'h00;
         link.resp_ready <= 1'b0;
      end else begin
         link.resp_ready <= 1'b1;
         if (state_r == sks_pkg::SKS_IDLE && start && !ptr_clash) begin
            link.req_valid <= 1'b1;
            link.req_is_8x8 <= ctrl_now[sks_pkg::CTRL_IS8X8];
            link.req_mask_return <= ctrl_now[sks_pkg::CTRL_MRET];
            link.req_fmt_10bit <= ctrl_now[sks_pkg::CTRL_FMT10];
            link.req_fmt_yuv <= ctrl_now[sks_pkg::CTRL_YUV];
            link.req_pixel_live <= ctrl_now[sks_pkg::CTRL_LIVE];
            link.req_sampler_index <= ctrl_now[sks_pkg::CTRL_IDX_LO +: 4];
            link.req_dw0 <= dw0_out;
            link.req_dw2 <= dw_r[2];
            link.req_dw3 <= dw_r[3];
            link.req_dw4 <= dw_r[4];
            link.req_texel <= tex_r;
            link.req_key_table <= key_r;
            link.req_edge_mag <= meas_r[7:0];
            link.req_steep <= meas_r[15:8];
            link.req_mr <= meas_r[23:16];
            link.req_slope <= meas_r[31:24];
         end else if (state_r == sks_pkg::SKS_SEND && link.req_ready) begin
            link.req_valid <= 1'b0;
         end
      end
   end
endmodule : sks_thread

// ===== test/sks_link_sva.sv
`timescale 1ns/10ps
module sks_link_sva (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // link
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_is_8x8,
   input wire logic [3:0] req_sampler_index,
   input wire logic [31:0] req_dw0,
   input wire logic [31:0] req_dw2,
   input wire logic [31:0] req_dw3,
   input wire logic [7:0] req_edge_mag,
   input wire logic resp_valid,
   input wire logic resp_ready,
   input wire logic [31:0] resp_info
);
   logic [31:0] dw0_q;
   logic [31:0] dw3_q;
   logic [3:0] idx_q;
   wire take = req_valid && req_ready;
   // copy of the taken message, so the answer can be judged against its cause
   always_ff @(posedge clk) begin
      if (take) begin
         dw0_q <= req_dw0;
         dw3_q <= req_dw3;
         idx_q <= req_sampler_index;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_answer_next: assert property (take |=> resp_valid) else $error("no answer after take");
   a_hold_off: assert property (resp_valid && !resp_ready |-> !req_ready) else $error("taken while stalled");
   a_mask_hidden: assert property (resp_valid && !resp_info[0] |-> !resp_info[1])
      else $error("mask returned without flag");
   a_aniso_ratio: assert property (take && !req_is_8x8 |=> resp_info[14:10] == 5'(2 * dw0_q[21:19] + 2))
      else $error("wrong aniso ratio");
   a_round_mask: assert property (take && !req_is_8x8 |=> resp_info[20:15] == dw0_q[18:13])
      else $error("wrong rounding mask");
   a_elem_index: assert property (
      take && req_is_8x8 |=> resp_info[22:21] == idx_q[3:2] && resp_info[20:10] == 11'h000)
      else $error("wrong element index");
   a_scaler_type: assert property (take && req_is_8x8 |=> resp_info[3] == dw0_q[31])
      else $error("wrong scaler type");
   a_bypass_neutral: assert property (take && req_is_8x8 && req_dw0[29] |=> resp_info[9:5] == 5'h00)
      else $error("bypass not neutral");
   a_strong_edge: assert property (
      take && req_is_8x8 && !req_dw0[29] && req_edge_mag > req_dw2[7:4]
      |=> resp_info[6:5] == 2'h2 && resp_info[9:7] == dw3_q[30:28]) else $error("strong edge missed");
   a_weak_edge: assert property (
      take && req_is_8x8 && !req_dw0[29] && req_edge_mag > req_dw2[3:0]
      && req_edge_mag < req_dw2[7:4] |=> resp_info[6:5] == 2'h1 && resp_info[9:7] == dw3_q[26:24])
      else $error("weak edge missed");
   a_size_5x5: assert property (req_valid && req_is_8x8 && req_dw0[28] |-> req_dw0[27])
      else $error("detail filter sent without 5x5 size");
   a_key_off: assert property (take && !(req_is_8x8 ? req_dw0[18] : req_dw0[25]) |=> !resp_info[2])
      else $error("key match while disabled");
   c_eight: cover property (take && req_is_8x8);
   c_hit: cover property (resp_valid && resp_info[2]);
   c_mask: cover property (resp_valid && resp_info[1]);
endmodule : sks_link_sva

// ===== test/sampler_key_scaler_state_test.sv
`timescale 1ns/10ps
module sampler_key_scaler_state_test;
   logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic hit;
   logic [15:0] served;
   int n_errors = 0, checks_done = 0, cyc = 0;
   sks_link_if link ();
   sks_thread sks_thread_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   sks_sampler sks_sampler_i (.clk(clk), .reset_n(reset_n), .link(link), .key_hit_seen_r(hit),
      .served_count_r(served));
   sks_link_sva sks_link_sva_i (.clk(clk), .reset_n(reset_n), .req_valid(link.req_valid), .req_ready(link.req_ready),
      .req_is_8x8(link.req_is_8x8), .req_sampler_index(link.req_sampler_index), .req_dw0(link.req_dw0),
      .req_dw2(link.req_dw2), .req_dw3(link.req_dw3), .req_edge_mag(link.req_edge_mag),
      .resp_valid(link.resp_valid), .resp_ready(link.resp_ready), .resp_info(link.resp_info));
   initial forever #20 clk = ~clk;
   task test_done;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         test_done();
      end
   end
   task chk(input string s, input logic [31:0] a, input logic [31:0] b);
      checks_done++;
      if (b !== a) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", s, a, b);
      end
   endtask : chk
   // one apb transfer; read data and error flag land in d and e
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   initial begin
      logic e8, en, f10, yuv, mr, lv, mt, bp, hm;
      logic [1:0] ki, c;
      logic [2:0] wt;
      logic [3:0] ix;
      logic [7:0] mg, st, rm, sl;
      logic [31:0] x, t, k, w0, w2, w3, w4, ex, ei, em;
      int sg, rg, sh;
      x = $urandom(83);
      hm = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1;
      apb(0, 8'h0C, 0);
      chk("dw2", 32'h0000_1681, d);
      apb(0, 8'h10, 0);
      chk("dw3", 32'h721A_03C6, d);
      apb(0, 8'h80, 0);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1, 8'h08, 32'h0000_1000);
      for (int i = 0; i < 40; i++) begin
         x = $urandom;
         t = $urandom;
         k = $urandom & 32'h00FF_FFFF;
         w0 = $urandom;
         w2 = $urandom;
         w3 = $urandom;
         w4 = $urandom;
         e8 = i[0];
         f10 = x[0];
         yuv = x[1];
         mr = x[2];
         lv = x[3];
         mg = {3'h0, x[12:8]};
         st = x[23:16];
         rm = x[31:24];
         sl = 8'($urandom);
         // 8x8 indices that are not a multiple of four must raise the index error
         ix = x[7:4];
         bp = e8 & w0[29];
         en = e8 ? w0[18] : w0[25];
         ki = e8 ? w0[17:16] : w0[24:23];
         // two of three messages carry a texel equal to the key, 10-bit ones differing in the low bits
         if (i % 3 != 2)
            t = f10 ? {t[31:30], k[23:16], t[21:20], k[15:8], t[11:10], k[7:0], t[1:0]} : {t[31:24], k[23:0]};
         apb(1, 8'h04, w0);
         apb(1, 8'h0C, w2);
         apb(1, 8'h10, w3);
         apb(1, 8'h14, w4);
         apb(1, 8'h28, {sl, rm, st, mg});
         for (int j = 0; j < 4; j++) begin
            apb(1, 8'h18 + 8'(4 * j), t);
            apb(1, 8'h2C + 8'(4 * j), j == ki ? k : ~k);
         end
         apb(1, 8'h00, {20'h0, ix, 1'b0, lv, yuv, f10, mr, e8, 2'b01});
         do apb(0, 8'h3C, 0); while (d[1] !== 1'b1);
         chk("index error", e8 && ix[1:0] != 2'h0, d[3]);
         apb(1, 8'h3C, 32'h0000_000E);
         mt = en && (f10 ? {t[29:22], t[19:12], t[9:2]} : t[23:0]) == k[23:0];
         hm = hm | mt;
         ex = (mt && (e8 || w0[22])) ? (yuv ? (f10 ? 32'h2001_0200 : 32'h0080_1080) : 32'h0) : t;
         for (int j = 0; j < 4; j++) begin
            apb(0, 8'h44 + 8'(4 * j), 0);
            chk("texel", ex, d);
         end
         c = bp ? 2'h0 : mg > w2[7:4] ? 2'h2 : (mg > w2[3:0] && mg < w2[7:4]) ? 2'h1 : 2'h0;
         wt = bp ? 3'h0 : c == 2'h2 ? w3[30:28] : c == 2'h1 ? w3[26:24] : w3[22:20];
         // max ratio is 2:1 for code 0 and grows by two per step
         ei = {9'h0, ix[3:2], e8 ? 11'h0 : {w0[18:13], 5'(2 * w0[21:19] + 2)}, wt, c, bp, e8 & w0[31], mt,
            mr & lv & !(mt & !(e8 | w0[22])), mr};
         apb(0, 8'h40, 0);
         chk("info", ei, d);
         sg = (bp || st <= w4[11:8]) ? 0 : w4[7] ? 2 * st : st;
         rg = (bp || rm <= w4[6:3]) ? 0 : w4[2] ? 2 * rm : rm;
         sh = $signed(sl) * int'(wt);
         em = {2'h0, 12'(sh), 9'(rg), 9'(sg)};
         apb(0, 8'h54, 0);
         chk("meas", em, d);
      end
      // a new pointer without a flush in between must be refused
      apb(1, 8'h08, 32'h0000_2000);
      apb(1, 8'h00, 32'h0000_0005);
      apb(0, 8'h3C, 0);
      chk("pointer", 32'h4, d & 32'h6);
      chk("served", 32'd40, {16'h0, served});
      chk("key hit", hm, hit);
      test_done();
   end
endmodule : sampler_key_scaler_state_test
